// ---- hw/ssq_pkg.sv ----
// Constants and types shared by both ends of the start-up sequencer link.
// Assumes one 20 MHz clock on both ends and a synchronous parallel host bus.
package ssq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ = 20000;
  localparam int PD_MIN_NS = 100000;
  // Least time, so round up
  localparam int PD_CYCLES = (PD_MIN_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int RESET_CYCLES = 512;
  localparam int INIT_CYCLES = 128;
  localparam int CNT_W = 10;

  // ****************************************************************
  // Register space
  // ****************************************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] ADDR_PAGE = 6'h00;
  localparam logic [5:0] ADDR_CMD = 6'h01;
  localparam logic [5:0] ADDR_CFG_FIRST = 6'h10;
  localparam logic [5:0] ADDR_CFG_LAST = 6'h2F;
  localparam int CFG_BYTES = 32;
  localparam int CFG_IDX_W = 5;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h80;
  localparam logic [7:0] PAGE_IF_INIT = 8'h80;
  localparam logic [7:0] PAGE_LINEAR = 8'h00;
  localparam logic [5:0] CMD_STARTUP = 6'h3F;
  localparam logic [5:0] CMD_IDLE = 6'h00;
  localparam logic [1:0] COPY_SLOT = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SSQ_D_PD = 3'b000,
    SSQ_D_OSC = 3'b001,
    SSQ_D_RESET = 3'b010,
    SSQ_D_INIT = 3'b011,
    SSQ_D_IDLE = 3'b100,
    SSQ_D_IFOK = 3'b101,
    SSQ_D_LINEAR = 3'b110
  } ssq_dstate_t;

  typedef enum logic [3:0] {
    SSQ_H_IDLE = 4'b0000,
    SSQ_H_PD = 4'b0001,
    SSQ_H_POLL = 4'b0010,
    SSQ_H_POLL_WT = 4'b0011,
    SSQ_H_PAGE80 = 4'b0100,
    SSQ_H_CHK = 4'b0101,
    SSQ_H_CHK_WT = 4'b0110,
    SSQ_H_PAGE00 = 4'b0111,
    SSQ_H_READY = 4'b1000,
    SSQ_H_URD_WT = 4'b1001,
    SSQ_H_FAIL = 4'b1010
  } ssq_hstate_t;

  typedef enum logic [1:0] {
    SSQ_IF_NONE = 2'b00,
    SSQ_IF_SEPARATE = 2'b01,
    SSQ_IF_MUXED = 2'b10
  } ssq_iftype_t;

endpackage

// ---- hw/ssq_if.sv ----
// Link between the reader's start-up logic and the 8-bit host.
// Strobes are one-cycle pulses synchronous to the shared clock.
`timescale 1ns/10ps
interface ssq_if;
  logic pd_pin;
  logic ale;
  logic wr;
  logic rd;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic irq;
  logic irq_oe;

  modport dev (
    input pd_pin,
    input ale,
    input wr,
    input rd,
    input addr,
    input wdata,
    output rdata,
    output rvalid,
    output irq,
    output irq_oe
  );

  modport host (
    output pd_pin,
    output ale,
    output wr,
    output rd,
    output addr,
    output wdata,
    input rdata,
    input rvalid,
    input irq,
    input irq_oe
  );
endinterface

// ---- hw/ssq_dev.sv ----
// Reader-side start-up sequencer: power-down, reset, init copy, interface detection.
// Assumes supply_ok, osc_stable and nv_data synchronous; nv_data follows nv_addr.
`timescale 1ns/10ps

// How it works
// - Hold power-down while any supply is low
// - Host holds power-down pin high 100 us
// - Reset phase lasts exactly 512 stable cycles
// - Reset phase loads defined register reset values
// - Init phase of 128 cycles follows reset
// - Init copies stored bytes into 10h-2Fh
// - Command reads 3Fh once oscillator stable
// - After init enter idle, command 00h
// - Host polls command until it reads 00h
// - Host then writes 80h to page
// - Command reads 00h after interface detected
// - Page write 00h selects linear addressing
// - Detect interface type from access sequence
// - Power-down isolates inputs, freezes outputs, irq off
module ssq_dev (
  input wire logic clock,
  input wire logic rst_n,
  ssq_if.dev bus,
  input wire logic supply_ok,
  input wire logic osc_stable,
  input wire logic [7:0] nv_data,
  output logic [4:0] nv_addr,
  output logic [2:0] phase,
  output logic [1:0] if_type,
  output logic linear
);

  // ****************************************************************
  // State
  // ****************************************************************
  ssq_pkg::ssq_dstate_t state_ff, nxt_state;
  logic [ssq_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [5:0] cmd_ff;
  logic [7:0] page_ff;
  logic ale_seen_ff;
  logic [1:0] if_type_ff;
  logic linear_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic irq_oe_ff;
  logic [4:0] nv_addr_ff;
  logic [7:0] cfg_ff [ssq_pkg::CFG_BYTES];

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire pd_now = !supply_ok || bus.pd_pin;
  // Inputs are cut off while powered down; writes also while still starting up
  wire live = (state_ff == ssq_pkg::SSQ_D_IDLE) || (state_ff == ssq_pkg::SSQ_D_IFOK)
              || (state_ff == ssq_pkg::SSQ_D_LINEAR);
  wire bus_on = !pd_now && (state_ff != ssq_pkg::SSQ_D_PD);
  wire rd_ok = bus_on && bus.rd;
  wire wr_ok = bus_on && live && bus.wr;
  wire ale_ok = bus_on && bus.ale;
  wire hit_cmd = (bus.addr == ssq_pkg::ADDR_CMD);
  wire hit_page = (bus.addr == ssq_pkg::ADDR_PAGE);
  wire hit_cfg = linear_ff && (bus.addr >= ssq_pkg::ADDR_CFG_FIRST)
                 && (bus.addr <= ssq_pkg::ADDR_CFG_LAST);
  wire [4:0] cfg_idx = 5'(bus.addr - ssq_pkg::ADDR_CFG_FIRST);
  wire [4:0] copy_idx = cnt_ff[6:2];
  wire copy_now = (state_ff == ssq_pkg::SSQ_D_INIT) && (cnt_ff[1:0] == ssq_pkg::COPY_SLOT);
  wire reset_end = (cnt_ff == ssq_pkg::CNT_W'(ssq_pkg::RESET_CYCLES - 1));
  wire init_end = (cnt_ff == ssq_pkg::CNT_W'(ssq_pkg::INIT_CYCLES - 1));
  wire in_reset = (state_ff == ssq_pkg::SSQ_D_RESET);
  wire wr_page = wr_ok && hit_page;
  wire page80 = wr_page && (bus.wdata == ssq_pkg::PAGE_IF_INIT);
  wire page00 = wr_page && (bus.wdata == ssq_pkg::PAGE_LINEAR);
  wire [7:0] rd_mux = hit_cmd ? {2'h0, cmd_ff} :
                      hit_page ? page_ff :
                      hit_cfg ? cfg_ff[cfg_idx] : 8'h00;

  // ****************************************************************
  // Phase sequencing
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ssq_pkg::SSQ_D_PD: begin
        nxt_cnt = '0;
        if (!pd_now) begin
          nxt_state = ssq_pkg::SSQ_D_OSC;
        end
      end
      ssq_pkg::SSQ_D_OSC: begin
        if (osc_stable) begin
          nxt_state = ssq_pkg::SSQ_D_RESET;
        end
      end
      ssq_pkg::SSQ_D_RESET: begin
        if (osc_stable) begin
          nxt_cnt = cnt_ff + 1'b1;
          if (reset_end) begin
            nxt_state = ssq_pkg::SSQ_D_INIT;
            nxt_cnt = '0;
          end
        end
      end
      ssq_pkg::SSQ_D_INIT: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (init_end) begin
          nxt_state = ssq_pkg::SSQ_D_IDLE;
          nxt_cnt = '0;
        end
      end
      ssq_pkg::SSQ_D_IDLE: begin
        if (page80) begin
          nxt_state = ssq_pkg::SSQ_D_IFOK;
        end
      end
      ssq_pkg::SSQ_D_IFOK: begin
        if (page00) begin
          nxt_state = ssq_pkg::SSQ_D_LINEAR;
        end
      end
      ssq_pkg::SSQ_D_LINEAR: begin
        nxt_state = ssq_pkg::SSQ_D_LINEAR;
      end
      default: begin
        nxt_state = ssq_pkg::SSQ_D_PD;
        nxt_cnt = '0;
      end
    endcase
    if (pd_now) begin
      nxt_state = ssq_pkg::SSQ_D_PD;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ssq_pkg::SSQ_D_PD;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************************************
  // Command, page, detection
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= ssq_pkg::CMD_STARTUP;
      page_ff <= ssq_pkg::PAGE_RST;
      ale_seen_ff <= 1'b0;
      if_type_ff <= ssq_pkg::SSQ_IF_NONE;
      linear_ff <= 1'b0;
    end else if (state_ff == ssq_pkg::SSQ_D_PD || in_reset) begin
      // Reset values reloaded on every pass through reset
      cmd_ff <= ssq_pkg::CMD_STARTUP;
      page_ff <= ssq_pkg::PAGE_RST;
      ale_seen_ff <= 1'b0;
      if_type_ff <= ssq_pkg::SSQ_IF_NONE;
      linear_ff <= 1'b0;
    end else begin
      if (state_ff == ssq_pkg::SSQ_D_INIT && init_end) begin
        cmd_ff <= ssq_pkg::CMD_IDLE;
      end else if (wr_ok && hit_cmd && linear_ff) begin
        cmd_ff <= bus.wdata[5:0];
      end
      if (wr_page) begin
        page_ff <= bus.wdata;
      end
      if (ale_ok && !linear_ff) begin
        ale_seen_ff <= 1'b1;
      end
      // Latch on a strobe elsewhere would be a muxed bus; separate bus never pulses it
      if (page80 && state_ff == ssq_pkg::SSQ_D_IDLE) begin
        if_type_ff <= (ale_seen_ff || ale_ok) ? ssq_pkg::SSQ_IF_MUXED : ssq_pkg::SSQ_IF_SEPARATE;
        cmd_ff <= ssq_pkg::CMD_IDLE;
      end
      if (page00 && state_ff == ssq_pkg::SSQ_D_IFOK) begin
        linear_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Configuration copy
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nv_addr_ff <= '0;
    end else begin
      nv_addr_ff <= nxt_cnt[6:2];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ssq_pkg::CFG_BYTES; gi++) begin : g_cfg
      wire copy_me = copy_now && (copy_idx == ssq_pkg::CFG_IDX_W'(gi));
      wire host_me = wr_ok && hit_cfg && (cfg_idx == ssq_pkg::CFG_IDX_W'(gi));
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cfg_ff[gi] <= ssq_pkg::CFG_RST;
        end else if (in_reset) begin
          cfg_ff[gi] <= ssq_pkg::CFG_RST;
        end else if (copy_me) begin
          // Address held three cycles before the slot, so one-cycle memory is safe
          cfg_ff[gi] <= nv_data;
        end else if (host_me) begin
          cfg_ff[gi] <= bus.wdata;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Host read path and pin freeze
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else begin
      rdata_ff <= rd_ok ? rd_mux : 8'h00;
      rvalid_ff <= rd_ok;
      irq_oe_ff <= bus_on;
    end
  end

  assign bus.rdata = rdata_ff;
  assign bus.rvalid = rvalid_ff;
  assign bus.irq = 1'b0;
  assign bus.irq_oe = irq_oe_ff;
  assign nv_addr = nv_addr_ff;
  assign phase = state_ff;
  assign if_type = if_type_ff;
  assign linear = linear_ff;

endmodule // ssq_dev

// ---- hw/ssq_host.sv ----
// Host-side start-up driver: pulses the power-down pin, waits for idle,
// runs the interface handshake, then serves single register reads.
// Assumes the device answers every read with one rvalid pulse.
`timescale 1ns/10ps
module ssq_host #(
  parameter int PD_CYCLES = ssq_pkg::PD_CYCLES,
  parameter bit USE_ALE = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  ssq_if.host bus,
  input wire logic start,
  input wire logic usr_rd,
  input wire logic [5:0] usr_addr,
  output logic [7:0] usr_rdata,
  output logic usr_valid,
  output logic ready,
  output logic fail
);

  // ****************************************************************
  // State
  // ****************************************************************
  ssq_pkg::ssq_hstate_t state_ff, nxt_state;
  logic [15:0] cnt_ff;
  logic pd_ff, ale_ff, wr_ff, rd_ff;
  logic [5:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] usr_rdata_ff;
  logic usr_valid_ff;
  logic ready_ff;
  logic fail_ff;

  wire pd_done = (cnt_ff == 16'(PD_CYCLES - 1));
  wire got_idle = bus.rvalid && (bus.rdata[5:0] == ssq_pkg::CMD_IDLE);
  wire issue_rd = (state_ff == ssq_pkg::SSQ_H_POLL) || (state_ff == ssq_pkg::SSQ_H_CHK);
  wire issue_wr = (state_ff == ssq_pkg::SSQ_H_PAGE80) || (state_ff == ssq_pkg::SSQ_H_PAGE00);
  wire take_usr = (state_ff == ssq_pkg::SSQ_H_READY) && usr_rd;

  // ****************************************************************
  // Handshake sequence
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ssq_pkg::SSQ_H_IDLE: if (start) nxt_state = ssq_pkg::SSQ_H_PD;
      ssq_pkg::SSQ_H_PD: if (pd_done) nxt_state = ssq_pkg::SSQ_H_POLL;
      ssq_pkg::SSQ_H_POLL: nxt_state = ssq_pkg::SSQ_H_POLL_WT;
      ssq_pkg::SSQ_H_POLL_WT: begin
        if (got_idle) begin
          nxt_state = ssq_pkg::SSQ_H_PAGE80;
        end else if (bus.rvalid) begin
          nxt_state = ssq_pkg::SSQ_H_POLL;
        end
      end
      ssq_pkg::SSQ_H_PAGE80: nxt_state = ssq_pkg::SSQ_H_CHK;
      ssq_pkg::SSQ_H_CHK: nxt_state = ssq_pkg::SSQ_H_CHK_WT;
      ssq_pkg::SSQ_H_CHK_WT: begin
        if (got_idle) begin
          nxt_state = ssq_pkg::SSQ_H_PAGE00;
        end else if (bus.rvalid) begin
          nxt_state = ssq_pkg::SSQ_H_FAIL;
        end
      end
      ssq_pkg::SSQ_H_PAGE00: nxt_state = ssq_pkg::SSQ_H_READY;
      ssq_pkg::SSQ_H_READY: if (usr_rd) nxt_state = ssq_pkg::SSQ_H_URD_WT;
      ssq_pkg::SSQ_H_URD_WT: if (bus.rvalid) nxt_state = ssq_pkg::SSQ_H_READY;
      ssq_pkg::SSQ_H_FAIL: if (start) nxt_state = ssq_pkg::SSQ_H_PD;
      default: nxt_state = ssq_pkg::SSQ_H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ssq_pkg::SSQ_H_IDLE;
      cnt_ff <= '0;
      ready_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (state_ff == ssq_pkg::SSQ_H_PD) ? cnt_ff + 1'b1 : '0;
      // Status pins registered so they never glitch on a state decode
      ready_ff <= (nxt_state == ssq_pkg::SSQ_H_READY);
      fail_ff <= (nxt_state == ssq_pkg::SSQ_H_FAIL);
    end
  end

  // ****************************************************************
  // Bus strobes
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_ff <= 1'b0;
      ale_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= ssq_pkg::ADDR_PAGE;
      wdata_ff <= 8'h00;
      usr_rdata_ff <= 8'h00;
      usr_valid_ff <= 1'b0;
    end else begin
      pd_ff <= (nxt_state == ssq_pkg::SSQ_H_PD);
      rd_ff <= issue_rd || take_usr;
      wr_ff <= issue_wr;
      // A muxed bus announces every access with a latch strobe
      ale_ff <= USE_ALE && (issue_rd || issue_wr || take_usr);
      if (issue_rd) begin
        addr_ff <= ssq_pkg::ADDR_CMD;
      end else if (issue_wr) begin
        addr_ff <= ssq_pkg::ADDR_PAGE;
      end else if (take_usr) begin
        addr_ff <= usr_addr;
      end
      if (state_ff == ssq_pkg::SSQ_H_PAGE80) begin
        wdata_ff <= ssq_pkg::PAGE_IF_INIT;
      end else if (state_ff == ssq_pkg::SSQ_H_PAGE00) begin
        wdata_ff <= ssq_pkg::PAGE_LINEAR;
      end
      usr_valid_ff <= (state_ff == ssq_pkg::SSQ_H_URD_WT) && bus.rvalid;
      if ((state_ff == ssq_pkg::SSQ_H_URD_WT) && bus.rvalid) begin
        usr_rdata_ff <= bus.rdata;
      end
    end
  end

  assign bus.pd_pin = pd_ff;
  assign bus.ale = ale_ff;
  assign bus.wr = wr_ff;
  assign bus.rd = rd_ff;
  assign bus.addr = addr_ff;
  assign bus.wdata = wdata_ff;
  assign usr_rdata = usr_rdata_ff;
  assign usr_valid = usr_valid_ff;
  assign ready = ready_ff;
  assign fail = fail_ff;

endmodule // ssq_host

// ---- bench/ssq_assertions.sv ----
// Checker for the start-up link: phase timing and register answers.
// Assumes one clock shared by both ends; instantiated beside the link.
`timescale 1ns/10ps
module ssq_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pd_pin,
  input wire logic supply_ok,
  input wire logic osc_stable,
  input wire logic wr,
  input wire logic rd,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic irq_oe,
  input wire logic [2:0] phase,
  input wire logic [1:0] if_type,
  input wire logic linear
);
  // ****************************************************************
  // Phase counters
  // ****************************************************************
  logic [9:0] rcnt_ff;
  logic [9:0] nxt_rcnt;
  logic [7:0] icnt_ff;
  logic [7:0] nxt_icnt;

  // Oscillator gaps must not advance the reset count
  assign nxt_rcnt = (phase == ssq_pkg::SSQ_D_RESET) ?
                    rcnt_ff + {9'h000, osc_stable} : 10'h000;
  assign nxt_icnt = (phase == ssq_pkg::SSQ_D_INIT) ? icnt_ff + 8'h01 : 8'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_ff <= 10'h000;
      icnt_ff <= 8'h00;
    end else begin
      rcnt_ff <= nxt_rcnt;
      icnt_ff <= nxt_icnt;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_cmd_read;
    rd && addr == ssq_pkg::ADDR_CMD;
  endsequence
  sequence s_page80;
    wr && addr == ssq_pkg::ADDR_PAGE && wdata == ssq_pkg::PAGE_IF_INIT &&
      phase == ssq_pkg::SSQ_D_IDLE;
  endsequence
  sequence s_page00;
    wr && addr == ssq_pkg::ADDR_PAGE && wdata == ssq_pkg::PAGE_LINEAR &&
      phase == ssq_pkg::SSQ_D_IFOK;
  endsequence

  AST_PD_ENTRY: assert property ((pd_pin || !supply_ok) |=> phase == ssq_pkg::SSQ_D_PD)
    else $error("power-down not entered");
  AST_PD_IRQ: assert property ((phase == ssq_pkg::SSQ_D_PD &&
    $past(phase) == ssq_pkg::SSQ_D_PD) |-> !irq_oe)
    else $error("irq pin driven in power-down");
  AST_LEAVE_PD: assert property ((phase == ssq_pkg::SSQ_D_PD && supply_ok && !pd_pin)
    |=> phase == ssq_pkg::SSQ_D_OSC)
    else $error("power-down not left");
  AST_OSC_WAIT: assert property ((phase == ssq_pkg::SSQ_D_OSC && !osc_stable &&
    supply_ok && !pd_pin) |=> phase == ssq_pkg::SSQ_D_OSC)
    else $error("reset phase began before oscillator stable");
  AST_RESET_LEN: assert property ((phase == ssq_pkg::SSQ_D_INIT &&
    $past(phase) == ssq_pkg::SSQ_D_RESET) |-> rcnt_ff == 10'h200)
    else $error("reset phase length wrong");
  AST_RESET_CAP: assert property (phase == ssq_pkg::SSQ_D_RESET |-> rcnt_ff < 10'h200)
    else $error("reset phase overran");
  AST_INIT_LEN: assert property ((phase == ssq_pkg::SSQ_D_IDLE &&
    $past(phase) == ssq_pkg::SSQ_D_INIT) |-> icnt_ff == 8'h80)
    else $error("init phase length wrong");
  AST_CMD_STARTUP: assert property ((s_cmd_read ##0 phase == ssq_pkg::SSQ_D_RESET)
    |=> rvalid && rdata == {2'b00, ssq_pkg::CMD_STARTUP})
    else $error("command not 3F during start-up");
  AST_CMD_IDLE: assert property ((s_cmd_read ##0 phase >= ssq_pkg::SSQ_D_IDLE)
    |=> rvalid && rdata == 8'h00)
    else $error("command not 00 after init");
  AST_IFOK: assert property (s_page80 |=> phase == ssq_pkg::SSQ_D_IFOK &&
    if_type != ssq_pkg::SSQ_IF_NONE)
    else $error("interface type not detected");
  AST_LINEAR: assert property (s_page00 |-> ##[1:2] linear)
    else $error("linear addressing not entered");
  AST_NO_EARLY_WR: assert property (wr |-> phase >= ssq_pkg::SSQ_D_IDLE)
    else $error("host wrote before initialization finished");
  AST_FIRST_WR: assert property ((wr && phase == ssq_pkg::SSQ_D_IDLE) |->
    addr == ssq_pkg::ADDR_PAGE && wdata == ssq_pkg::PAGE_IF_INIT)
    else $error("first host write not the interface start value");
endmodule // ssq_assertions

// ---- bench/tb.sv ----
// Self-checking bench: both start-up ends joined by one link, with a checker.
// Assumes a 20 MHz clock; the host power-down pulse is cut to 20 cycles.
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b0;
  logic osc_en = 1'b0;
  logic osc_stable = 1'b0;
  logic start = 1'b0;
  logic usr_rd = 1'b0;
  logic [5:0] usr_addr = 6'h00;
  logic [7:0] nvm [32];
  logic [7:0] nv_data;
  logic [4:0] nv_addr;
  logic [2:0] phase;
  logic [1:0] if_type;
  logic linear;
  logic [7:0] usr_rdata;
  logic usr_valid;
  logic ready;
  logic fail;
  int fails = 0;
  int n_compared = 0;
  int n_rst = 0;
  int n_init = 0;
  int n_pd = 0;
  logic [7:0] exp_q[$];

  ssq_if bus ();
  always #25 clock = ~clock;
  assign nv_data = nvm[nv_addr];

  ssq_dev u_ssq_dev (.clock(clock), .rst_n(rst_n), .bus(bus), .supply_ok(supply_ok),
    .osc_stable(osc_stable), .nv_data(nv_data), .nv_addr(nv_addr), .phase(phase),
    .if_type(if_type), .linear(linear));
  ssq_host #(.PD_CYCLES(20), .USE_ALE(1'b0)) u_ssq_host (.clock(clock), .rst_n(rst_n),
    .bus(bus), .start(start), .usr_rd(usr_rd), .usr_addr(usr_addr), .usr_rdata(usr_rdata),
    .usr_valid(usr_valid), .ready(ready), .fail(fail));
  ssq_assertions u_ssq_assertions (.clock(clock), .rst_n(rst_n), .pd_pin(bus.pd_pin),
    .supply_ok(supply_ok), .osc_stable(osc_stable), .wr(bus.wr), .rd(bus.rd),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid),
    .irq_oe(bus.irq_oe), .phase(phase), .if_type(if_type), .linear(linear));

  // ****************************************************************
  // Model and helpers
  // ****************************************************************
  // Gaps only inside the reset phase, where they must stretch the count
  always @(posedge clock)
    osc_stable <= #1 osc_en && (phase !== ssq_pkg::SSQ_D_RESET || $urandom % 4 != 0);

  always @(posedge clock) begin
    if (bus.pd_pin === 1'b1) n_pd++;
    if (phase === ssq_pkg::SSQ_D_PD) begin
      n_rst = 0;
      n_init = 0;
    end else begin
      if (phase === ssq_pkg::SSQ_D_RESET && osc_stable) n_rst++;
      if (phase === ssq_pkg::SSQ_D_INIT) n_init++;
    end
    if (usr_valid === 1'b1 && exp_q.size() != 0) check(usr_rdata, exp_q.pop_front());
  end

  function automatic logic [7:0] model_rd(input logic [5:0] a);
    if (a >= ssq_pkg::ADDR_CFG_FIRST && a <= ssq_pkg::ADDR_CFG_LAST) return nvm[5'(a - 6'h10)];
    return 8'h00;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wait_for(input logic [2:0] p, input int lim);
    for (int k = 0; k < lim && phase !== p; k++) step(1);
  endtask

  task automatic usr_read(input logic [5:0] a);
    usr_addr = a;
    usr_rd = 1'b1;
    exp_q.push_back(model_rd(a));
    step(1);
    usr_rd = 1'b0;
    for (int k = 0; k < 20 && exp_q.size() != 0; k++) step(1);
    step(1);
  endtask

  task automatic bring_up();
    n_pd = 0;
    start = 1'b1;
    step(1);
    start = 1'b0;
    wait_for(ssq_pkg::SSQ_D_PD, 5);
    check(16'(phase), 16'(ssq_pkg::SSQ_D_PD));
    wait_for(ssq_pkg::SSQ_D_IDLE, 2000);
    check(16'(n_rst), 16'h0200);
    check(16'(n_init), 16'h0080);
    check(16'(n_pd), 16'h0014);
    for (int k = 0; k < 200 && ready !== 1'b1; k++) step(1);
    // The final page write lands one edge after ready rises
    step(1);
    check({14'h0000, ready, fail}, 16'h0002);
    check({15'h0000, linear}, 16'h0001);
    check(16'(if_type), 16'(ssq_pkg::SSQ_IF_SEPARATE));
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    void'($urandom(32'h1182));
    foreach (nvm[i]) nvm[i] = 8'($urandom);
    step(5);
    rst_n = 1'b1;
    step(4);
    check(16'(phase), 16'(ssq_pkg::SSQ_D_PD));
    check({15'h0000, bus.irq_oe}, 16'h0000);
    supply_ok = 1'b1;
    step(3);
    check(16'(phase), 16'(ssq_pkg::SSQ_D_OSC));
    osc_en = 1'b1;
    wait_for(ssq_pkg::SSQ_D_RESET, 10);
    step(100);
    supply_ok = 1'b0;
    step(2);
    check(16'(phase), 16'(ssq_pkg::SSQ_D_PD));
    supply_ok = 1'b1;
    bring_up();
    for (int a = 0; a < 64; a++) usr_read(6'(a));
    repeat (16) usr_read(6'($urandom));
    // Reset in mid-run must drop linear mode until the handshake repeats
    rst_n = 1'b0;
    step(2);
    check({14'h0000, ready, linear}, 16'h0000);
    rst_n = 1'b1;
    bring_up();
    usr_read(6'h2F);
    check(16'(exp_q.size()), 16'h0000);
    finish_test();
  end

  initial begin
    #(20000 * 50);
    fails++;
    finish_test();
  end
endmodule // tb
